// *** logic/sli_pkg.sv ***
// Purpose: Shared constants of the sync line interrupt and clear logic
// Assumes: 16-bit registers, one clock, plain configuration ports
// Notes:   Flag and select layouts are fixed here only
package sli_pkg;
  localparam int          DW           = 16;
  localparam int          NFLAG        = 14;
  localparam int          FIFO_DEPTH   = 16;
  // Configuration selects
  localparam logic [3:0]  SEL_XCSR     = 4'h0;
  localparam logic [3:0]  SEL_REGERR   = 4'h1;
  localparam logic [3:0]  SEL_SYNC     = 4'h2;
  localparam logic [3:0]  SEL_MISC     = 4'h3;
  localparam logic [3:0]  SEL_POLY     = 4'h4;
  localparam logic [3:0]  SEL_STATUS   = 4'h5;
  localparam int          SEL_MEM_BIT  = 3;
  localparam int          SEL_CNT_BIT  = 2;
  // Transmit control/status fields
  localparam int          XCSR_TX_IE   = 0;
  localparam int          XCSR_RX_IE   = 1;
  localparam int          XCSR_FAULT_IRQ_ENABLE  = 2;
  localparam int          XCSR_MDM_IE  = 3;
  localparam int          XCSR_CHR_IE  = 4;
  localparam int          XCSR_LVL_LSB = 5;
  // Writable bit masks
  localparam logic [15:0] XCSR_WMASK   = 16'h007f;
  localparam logic [15:0] REGERR_WMASK = 16'h00ff;
  localparam logic [15:0] MISC_WMASK   = 16'h8fcb;
  localparam logic [15:0] ZERO16       = 16'h0000;
  // Flag positions
  localparam int          F_RX_FIRST   = 0;
  localparam int          F_RX_SECOND  = 1;
  localparam int          F_TX_FIRST   = 2;
  localparam int          F_TX_SECOND  = 3;
  localparam int          F_MODEM      = 4;
  localparam int          F_CHAR       = 5;
  localparam int          F_TX_MISSING = 10;
  localparam int          F_RX_MISSING = 11;
  localparam logic [13:0] TX_MASK      = 14'h000c;
  localparam logic [13:0] FAULT_MASK   = 14'h3fc0;
  localparam logic [13:0] RX_MASK      = 14'h3ff3;
  // Bus priority of the highest level
  localparam logic [2:0]  LVL_TOP      = 3'h7;
  localparam logic        DIR_RX       = 1'b0;
  localparam logic        DIR_TX       = 1'b1;
  typedef enum logic {SLI_IDLE, SLI_XFER} sli_dma_t;
endpackage

// *** logic/sli_fifo.sv ***
// Purpose: Receive word FIFO between line and memory transfer engine
// Assumes: Synchronous active-high reset
// Notes:   Ready and valid are registered so they never ripple
`timescale 1ns/1ps
module sli_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // Drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic          rdy_reg, rdy_next, vld_reg, vld_next;
  logic          push, pop;

  always_comb begin
    push     = in_valid & rdy_reg;
    pop      = out_ready & vld_reg;
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
    rdy_next = (cnt_next != CW'(DEPTH));
    vld_next = (cnt_next != '0);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b0;
      vld_reg <= 1'b0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
      vld_reg <= vld_next;
    end
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  assign in_ready  = rdy_reg;
  assign out_valid = vld_reg;
  assign out_data  = mem[rd_reg];
endmodule

// *** logic/sli_irq_ctrl.sv ***
// Purpose: Interrupt, master clear and memory transfer logic of a sync line
// Assumes: Inputs synchronous to CLK; bus answers with done or no-memory
// Notes:   Serialiser, sync detect and block check live elsewhere
// Behaviour
// [R1] Master clear zeroes every writable transmit control/status bit.
// [R2] Master clear zeroes writable register-select/error bits.
// [R3] Master clear zeroes the sync character register.
// [R4] Master clear zeroes writable miscellaneous configuration bits.
// [R5] Master clear zeroes the block-check polynomial register.
// [R6] Receive-done enable with either receive-done flag requests receive interrupt.
// [R7] Transmit-done enable with either transmit-done flag requests transmit interrupt.
// [R8] Error enable with any clock loss, latency, memory or check fault requests.
// [R9] Modem enable with modem change flag requests an interrupt.
// [R10] Character-match enable with match flag requests an interrupt.
// [R11] Receive interrupt is presented before a simultaneous transmit interrupt.
// [R12] One transmit interrupt per event, never repeated after acknowledge.
// [R13] One receive interrupt per event, never repeated after acknowledge.
// [R14] Request level selectable among four, 7 highest down to 4.
// [R15] Each direction masters memory via primary or secondary address/count pair.
// [R16] Missing memory on a transfer sets that direction's missing-memory flag.
// [R17] Master clear resets receive pair selection to primary.
// [R18] Master clear resets transmit pair selection to primary.
// [R19] Flags stay set until software clear or master clear.
`timescale 1ns/1ps
module sli_irq_ctrl #(
  parameter int DEPTH = sli_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        MASTER_CLEAR,
  // Configuration access
  input  wire logic        CFG_WR,
  input  wire logic [3:0]  CFG_SEL,
  input  wire logic [15:0] CFG_WDATA,
  output logic      [15:0] CFG_RDATA,
  // Event flags
  input  wire logic [13:0] EVENT_SET,
  input  wire logic [13:0] FLAG_CLR,
  output logic      [13:0] FLAGS,
  output logic             RX_PAIR_SEL,
  output logic             TX_PAIR_SEL,
  // Interrupt request
  output logic             IRQ_REQ,
  output logic      [2:0]  IRQ_LEVEL,
  output logic             IRQ_VEC_TX,
  input  wire logic        IRQ_ACK,
  // Memory bus master
  output logic             DIRECT_MEMORY_REQUEST,
  output logic      [15:0] BUS_ADDR,
  output logic             BUS_WRITE,
  output logic      [15:0] BUS_WDATA,
  input  wire logic [15:0] BUS_RDATA,
  input  wire logic        BUS_DONE,
  input  wire logic        BUS_NXM,
  // Line data
  input  wire logic [15:0] RX_DATA,
  input  wire logic        RX_VALID,
  output logic             RX_READY,
  output logic      [15:0] TX_DATA,
  output logic             TX_VALID,
  input  wire logic        TX_READY
);
  function automatic logic [1:0] slot_of(input logic dir, input logic [1:0] ps);
    slot_of = {dir, ps[dir]};
  endfunction
  logic [15:0] xcsr_reg, xcsr_next, regerr_reg, regerr_next;
  logic [15:0] sync_reg, sync_next, misc_reg, misc_next;
  logic [15:0] poly_reg, poly_next, rdata_reg, rdata_next;
  logic [13:0] flags_reg, flags_next, terms_q_reg, terms, en_vec, dma_set;
  logic        rx_pend_reg, rx_pend_next, tx_pend_reg, tx_pend_next;
  logic        req_reg, req_next, vec_reg, vec_next, ack, trig_rx, trig_tx;
  logic [2:0]  lvl_reg, lvl_next;
  sli_pkg::sli_dma_t st_reg, st_next;
  logic [15:0] addr_mem [4], addr_mem_next [4];
  logic [15:0] cnt_mem [4], cnt_mem_next [4];
  logic [1:0]  ps_reg, ps_next, s;
  logic        dir_reg, dir_next, breq_reg, breq_next, bwe_reg, bwe_next;
  logic [15:0] baddr_reg, baddr_next, bwd_reg, bwd_next, txd_reg, txd_next, f_data;
  logic        txv_reg, txv_next, rx_live, tx_live, f_valid, f_pop, f_in_ready;
  sli_fifo #(.W(sli_pkg::DW), .DEPTH(DEPTH)) u_fifo (
    .clk      (CLK),     .rst       (SYS_RST),
    .in_data  (RX_DATA), .in_valid  (RX_VALID), .in_ready  (f_in_ready),
    .out_data (f_data),  .out_valid (f_valid),  .out_ready (f_pop)
  );
  // Configuration registers; master clear outranks a write
  always_comb begin
    xcsr_next   = xcsr_reg;
    regerr_next = regerr_reg;
    sync_next   = sync_reg;
    misc_next   = misc_reg;
    poly_next   = poly_reg;
    if (CFG_WR) begin
      unique case (CFG_SEL)
        sli_pkg::SEL_XCSR:   xcsr_next   = CFG_WDATA & sli_pkg::XCSR_WMASK;
        sli_pkg::SEL_REGERR: regerr_next = CFG_WDATA & sli_pkg::REGERR_WMASK;
        sli_pkg::SEL_SYNC:   sync_next   = CFG_WDATA;
        sli_pkg::SEL_MISC:   misc_next   = CFG_WDATA & sli_pkg::MISC_WMASK;
        sli_pkg::SEL_POLY:   poly_next   = CFG_WDATA;
        default:             ;
      endcase
    end
    if (MASTER_CLEAR) begin
      xcsr_next   = sli_pkg::ZERO16; // [R1]
      regerr_next = sli_pkg::ZERO16; // [R2]
      sync_next   = sli_pkg::ZERO16; // [R3]
      misc_next   = sli_pkg::ZERO16; // [R4]
      poly_next   = sli_pkg::ZERO16; // [R5]
    end
    if (CFG_SEL[sli_pkg::SEL_MEM_BIT]) begin
      rdata_next = CFG_SEL[sli_pkg::SEL_CNT_BIT] ? cnt_mem[CFG_SEL[1:0]] : addr_mem[CFG_SEL[1:0]];
    end else begin
      unique case (CFG_SEL)
        sli_pkg::SEL_XCSR:   rdata_next = xcsr_reg;
        sli_pkg::SEL_REGERR: rdata_next = regerr_reg;
        sli_pkg::SEL_SYNC:   rdata_next = sync_reg;
        sli_pkg::SEL_MISC:   rdata_next = misc_reg;
        sli_pkg::SEL_POLY:   rdata_next = poly_reg;
        sli_pkg::SEL_STATUS: rdata_next = {ps_reg, flags_reg};
        default:             rdata_next = sli_pkg::ZERO16;
      endcase
    end
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      xcsr_reg   <= '0;
      regerr_reg <= '0;
      sync_reg   <= '0;
      misc_reg   <= '0;
      poly_reg   <= '0;
      rdata_reg  <= '0;
    end else begin
      xcsr_reg   <= xcsr_next;
      regerr_reg <= regerr_next;
      sync_reg   <= sync_next;
      misc_reg   <= misc_next;
      poly_reg   <= poly_next;
      rdata_reg  <= rdata_next;
    end
  end
  // Flags; a set in a software-clear cycle survives, a master clear drops it
  always_comb begin
    en_vec = {{8{xcsr_reg[sli_pkg::XCSR_FAULT_IRQ_ENABLE]}},                 // [R8]
              xcsr_reg[sli_pkg::XCSR_CHR_IE],                      // [R10]
              xcsr_reg[sli_pkg::XCSR_MDM_IE],                      // [R9]
              {2{xcsr_reg[sli_pkg::XCSR_TX_IE]}},                  // [R7]
              {2{xcsr_reg[sli_pkg::XCSR_RX_IE]}}};                 // [R6]
    terms      = flags_reg & en_vec;
    flags_next = (flags_reg & ~FLAG_CLR) | EVENT_SET | dma_set;   // [R19]
    if (MASTER_CLEAR) begin
      flags_next = '0;
    end
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      flags_reg   <= '0;
      terms_q_reg <= '0;
    end else begin
      flags_reg   <= flags_next;
      terms_q_reg <= terms;
    end
  end
  // Interrupt presentation; only a fresh rise of a term arms a request
  always_comb begin
    trig_rx      = |(terms & ~terms_q_reg & sli_pkg::RX_MASK);    // [R13]
    trig_tx      = |(terms & ~terms_q_reg & sli_pkg::TX_MASK);    // [R12]
    ack          = IRQ_ACK & req_reg;
    rx_pend_next = trig_rx | (rx_pend_reg & ~(ack & ~vec_reg));    // [R13]
    tx_pend_next = trig_tx | (tx_pend_reg & ~(ack & vec_reg));     // [R12]
    req_next     = req_reg;
    vec_next     = vec_reg;
    lvl_next     = lvl_reg;
    if (req_reg) begin
      req_next = ~ack;
    end else if (rx_pend_reg || tx_pend_reg) begin
      req_next = 1'b1;
      vec_next = ~rx_pend_reg;                                     // [R11]
      lvl_next = sli_pkg::LVL_TOP - {1'b0, xcsr_reg[sli_pkg::XCSR_LVL_LSB +: 2]}; // [R14]
    end
    if (MASTER_CLEAR) begin
      rx_pend_next = 1'b0;
      tx_pend_next = 1'b0;
      req_next     = 1'b0;
    end
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rx_pend_reg <= 1'b0;
      tx_pend_reg <= 1'b0;
      req_reg     <= 1'b0;
      vec_reg     <= 1'b0;
      lvl_reg     <= sli_pkg::LVL_TOP;
    end else begin
      rx_pend_reg <= rx_pend_next;
      tx_pend_reg <= tx_pend_next;
      req_reg     <= req_next;
      vec_reg     <= vec_next;
      lvl_reg     <= lvl_next;
    end
  end
  // Transfer engine; receive served first as it cannot be stalled for long
  always_comb begin
    st_next       = st_reg;
    addr_mem_next = addr_mem;
    cnt_mem_next  = cnt_mem;
    ps_next       = ps_reg;
    dir_next      = dir_reg;
    breq_next     = breq_reg;
    bwe_next      = bwe_reg;
    baddr_next    = baddr_reg;
    bwd_next      = bwd_reg;
    txd_next      = txd_reg;
    txv_next      = txv_reg & ~TX_READY;
    dma_set       = '0;
    f_pop         = 1'b0;
    rx_live       = cnt_mem[slot_of(sli_pkg::DIR_RX, ps_reg)] != '0;
    tx_live       = cnt_mem[slot_of(sli_pkg::DIR_TX, ps_reg)] != '0;
    s             = slot_of(dir_reg, ps_reg);
    unique case (st_reg)
      sli_pkg::SLI_IDLE: begin
        if (rx_live && f_valid) begin                              // [R15]
          f_pop      = 1'b1;
          dir_next   = sli_pkg::DIR_RX;
          breq_next  = 1'b1;
          bwe_next   = 1'b1;
          bwd_next   = f_data;
          baddr_next = addr_mem[slot_of(sli_pkg::DIR_RX, ps_reg)];
          st_next    = sli_pkg::SLI_XFER;
        end else if (tx_live && !txv_reg) begin                    // [R15]
          dir_next   = sli_pkg::DIR_TX;
          breq_next  = 1'b1;
          bwe_next   = 1'b0;
          baddr_next = addr_mem[slot_of(sli_pkg::DIR_TX, ps_reg)];
          st_next    = sli_pkg::SLI_XFER;
        end
      end
      sli_pkg::SLI_XFER: begin
        if (BUS_NXM) begin
          breq_next = 1'b0;
          st_next   = sli_pkg::SLI_IDLE;
          cnt_mem_next[s] = '0;
          dma_set[dir_reg ? sli_pkg::F_TX_MISSING : sli_pkg::F_RX_MISSING] = 1'b1; // [R16]
        end else if (BUS_DONE) begin
          breq_next = 1'b0;
          st_next   = sli_pkg::SLI_IDLE;
          addr_mem_next[s] = addr_mem[s] + 16'h0001;
          cnt_mem_next[s]  = cnt_mem[s] - 16'h0001;
          if (dir_reg) begin
            txd_next = BUS_RDATA;
            txv_next = 1'b1;
          end
          if (cnt_mem[s] == 16'h0001) begin
            dma_set[{dir_reg, ps_reg[dir_reg]}] = 1'b1;
            ps_next[dir_reg] = ~ps_reg[dir_reg];
          end
        end
      end
    endcase
    if (CFG_WR && CFG_SEL[sli_pkg::SEL_MEM_BIT]) begin
      if (CFG_SEL[sli_pkg::SEL_CNT_BIT]) begin
        cnt_mem_next[CFG_SEL[1:0]] = CFG_WDATA;
      end else begin
        addr_mem_next[CFG_SEL[1:0]] = CFG_WDATA;
      end
    end
    if (MASTER_CLEAR) begin
      ps_next = 2'h0;                                              // [R17] [R18]
    end
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_reg    <= sli_pkg::SLI_IDLE;
      addr_mem  <= '{default: '0};
      cnt_mem   <= '{default: '0};
      ps_reg    <= '0;
      dir_reg   <= 1'b0;
      breq_reg  <= 1'b0;
      bwe_reg   <= 1'b0;
      baddr_reg <= '0;
      bwd_reg   <= '0;
      txd_reg   <= '0;
      txv_reg   <= 1'b0;
    end else begin
      st_reg    <= st_next;
      addr_mem  <= addr_mem_next;
      cnt_mem   <= cnt_mem_next;
      ps_reg    <= ps_next;
      dir_reg   <= dir_next;
      breq_reg  <= breq_next;
      bwe_reg   <= bwe_next;
      baddr_reg <= baddr_next;
      bwd_reg   <= bwd_next;
      txd_reg   <= txd_next;
      txv_reg   <= txv_next;
    end
  end
  assign CFG_RDATA             = rdata_reg;
  assign FLAGS                 = flags_reg;
  assign RX_PAIR_SEL           = ps_reg[0];
  assign TX_PAIR_SEL           = ps_reg[1];
  assign IRQ_REQ               = req_reg;
  assign IRQ_LEVEL             = lvl_reg;
  assign IRQ_VEC_TX            = vec_reg;
  assign DIRECT_MEMORY_REQUEST = breq_reg;
  assign BUS_ADDR              = baddr_reg;
  assign BUS_WRITE             = bwe_reg;
  assign BUS_WDATA             = bwd_reg;
  assign RX_READY              = f_in_ready;
  assign TX_DATA               = txd_reg;
  assign TX_VALID              = txv_reg;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_clear_xcsr: assert property (MASTER_CLEAR |=> xcsr_reg == '0) else $error("xcsr kept"); // [R1]
  a_clear_regerr: assert property (MASTER_CLEAR |=> regerr_reg == '0) else $error("kept"); // [R2]
  a_clear_sync: assert property (MASTER_CLEAR |=> sync_reg == '0) else $error("sync kept"); // [R3]
  a_clear_misc: assert property (MASTER_CLEAR |=> misc_reg == '0) else $error("misc kept"); // [R4]
  a_clear_poly: assert property (MASTER_CLEAR |=> poly_reg == '0) else $error("poly kept"); // [R5]
  a_rx_done_req: assert property ((!MASTER_CLEAR && xcsr_reg[sli_pkg::XCSR_RX_IE] // [R6]
      && flags_reg[1:0] != '0 && terms_q_reg[1:0] == '0) |=> rx_pend_reg)
    else $error("receive done did not arm");
  a_tx_done_req: assert property ((!MASTER_CLEAR && xcsr_reg[sli_pkg::XCSR_TX_IE] // [R7]
      && flags_reg[3:2] != '0 && terms_q_reg[3:2] == '0) |=> tx_pend_reg)
    else $error("transmit done did not arm");
  a_fault_req: assert property ((!MASTER_CLEAR && xcsr_reg[sli_pkg::XCSR_FAULT_IRQ_ENABLE] // [R8]
      && (flags_reg & sli_pkg::FAULT_MASK & ~terms_q_reg) != '0) |=> rx_pend_reg)
    else $error("fault did not arm");
  a_rx_first: assert property ((!req_reg && rx_pend_reg && !MASTER_CLEAR) // [R11]
      |=> req_reg && !vec_reg) else $error("receive not presented first");
  a_tx_once: assert property ((ack && vec_reg && !trig_tx && !MASTER_CLEAR) // [R12]
      |=> !tx_pend_reg ##1 (!req_reg || !vec_reg)) else $error("transmit repeated");
  a_level_map: assert property ((!req_reg && (rx_pend_reg || tx_pend_reg) // [R14]
      && !MASTER_CLEAR) |=> lvl_reg == sli_pkg::LVL_TOP - {1'b0, $past(xcsr_reg[6:5])})
    else $error("wrong request level");
  a_nxm_flag: assert property ((st_reg == sli_pkg::SLI_XFER && BUS_NXM && !MASTER_CLEAR) // [R16]
      |=> flags_reg[$past(dir_reg) ? sli_pkg::F_TX_MISSING : sli_pkg::F_RX_MISSING])
    else $error("missing memory not flagged");
  a_pair_clear: assert property (MASTER_CLEAR |=> ps_reg == 2'h0) else $error("ps kept"); // [R17]
  a_flag_hold: assert property ((flags_reg[0] && !FLAG_CLR[0] && !MASTER_CLEAR) // [R19]
      |=> flags_reg[0]) else $error("flag dropped");
endmodule

// *** testbench/sli_mem_model.sv ***
// Purpose: Memory bus partner for the transfer engine
// Assumes: One answer pulse per request, after an optional wait
// Notes:   Addresses from NXM_BASE up answer with no-memory
`timescale 1ns/1ps
module sli_mem_model #(
  parameter logic [15:0] NXM_BASE = 16'h8000
) (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic        req,
  input  wire logic [15:0] addr,
  input  wire logic        wr,
  input  wire logic [15:0] wdata,
  output logic      [15:0] rdata,
  output logic             done,
  output logic             nxm
);
  logic [15:0] mem [0:63];
  logic [2:0]  cnt = 3'h0;
  initial begin
    rdata = 16'h0000;
    done  = 1'b0;
    nxm   = 1'b0;
  end
  always @(posedge clk) begin
    // Stale read data keeps changing so it never looks valid
    rdata <= ~rdata;
    done  <= 1'b0;
    nxm   <= 1'b0;
    if (!req || done || nxm) begin
      cnt <= 3'h0;
    end else if (cnt < (slow ? 3'h4 : 3'h0)) begin
      cnt <= cnt + 3'h1;
    end else if (addr >= NXM_BASE) begin
      nxm <= 1'b1;
    end else begin
      done <= 1'b1;
      if (wr) begin
        mem[addr[5:0]] <= wdata;
      end else begin
        rdata <= mem[addr[5:0]];
      end
    end
  end
endmodule

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench of the interrupt and clear logic
// Assumes: Inputs change at the falling edge
// Notes:   Slot and flag layout as fixed by the design
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        mclr = 1'b0;
  logic        cwr = 1'b0;
  logic [3:0]  csel = 4'h0;
  logic [15:0] cwd = 16'h0000;
  logic [15:0] crd, baddr, bwd, brd, txd, d;
  logic [13:0] evs = 14'h0000;
  logic [13:0] fclr = 14'h0000;
  logic [13:0] flags;
  logic        rxp, txp, irq, vtx, dreq, bwr, bdone, bnxm, rxr, txv;
  logic [2:0]  lvl;
  logic        ack = 1'b0;
  logic        slow = 1'b0;
  logic [15:0] rxd = 16'h0000;
  logic        rxv = 1'b0;
  logic        txr = 1'b0;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  sli_irq_ctrl DUT (.CLK(clk), .SYS_RST(rst), .MASTER_CLEAR(mclr), .CFG_WR(cwr),
    .CFG_SEL(csel), .CFG_WDATA(cwd), .CFG_RDATA(crd), .EVENT_SET(evs), .FLAG_CLR(fclr),
    .FLAGS(flags), .RX_PAIR_SEL(rxp), .TX_PAIR_SEL(txp), .IRQ_REQ(irq), .IRQ_LEVEL(lvl),
    .IRQ_VEC_TX(vtx), .IRQ_ACK(ack), .DIRECT_MEMORY_REQUEST(dreq), .BUS_ADDR(baddr),
    .BUS_WRITE(bwr), .BUS_WDATA(bwd), .BUS_RDATA(brd), .BUS_DONE(bdone), .BUS_NXM(bnxm),
    .RX_DATA(rxd), .RX_VALID(rxv), .RX_READY(rxr), .TX_DATA(txd), .TX_VALID(txv),
    .TX_READY(txr));
  sli_mem_model MEM (.clk(clk), .slow(slow), .req(dreq), .addr(baddr), .wr(bwr),
    .wdata(bwd), .rdata(brd), .done(bdone), .nxm(bnxm));

  always #10 clk = ~clk;

  task automatic wrap_up;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Ceiling well above the several hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("CHECK FAILED at %0t: timeout", $time);
      wrap_up();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] s, input logic [15:0] v);
    csel = s;
    cwd  = v;
    cwr  = 1'b1;
    @(negedge clk);
    cwr = 1'b0;
    // Let an edge pass so a following write raises the strobe afresh
    @(negedge clk);
  endtask
  task automatic rd(input logic [3:0] s, output logic [15:0] v);
    csel = s;
    repeat (2) @(negedge clk);
    v = crd;
  endtask
  task automatic pulse(input logic [13:0] b, input logic clr);
    if (clr) fclr = b;
    else evs = b;
    @(negedge clk);
    evs  = 14'h0000;
    fclr = 14'h0000;
    @(negedge clk);
  endtask
  task automatic mclear;
    mclr = 1'b1;
    @(negedge clk);
    mclr = 1'b0;
    @(negedge clk);
  endtask
  task automatic take_irq(input logic v, input logic [2:0] l);
    for (int i = 0; i < 20 && irq !== 1'b1; i++) @(negedge clk);
    chk(16'(irq), 16'h0001, "irq");
    chk(16'(vtx), 16'(v), "vector");
    chk(16'(lvl), 16'(l), "level");
    ack = 1'b1;
    @(negedge clk);
    ack = 1'b0;
    chk(16'(irq), 16'h0000, "irq after ack");
  endtask
  task automatic wait_flag(input int b);
    for (int i = 0; i < 600 && flags[b] !== 1'b1; i++) @(negedge clk);
    chk(16'(flags[b]), 16'h0001, "flag set");
  endtask

  task automatic t_reset;
    chk(16'(irq), 16'h0000, "reset irq");
    chk(16'(lvl), 16'h0007, "reset level");
    chk(16'(rxr), 16'h0001, "reset ready");
  endtask
  task automatic t_clear;
    logic [15:0] m [0:4];
    m = '{sli_pkg::XCSR_WMASK, sli_pkg::REGERR_WMASK, 16'hffff, sli_pkg::MISC_WMASK, 16'hffff};
    for (int i = 0; i < 5; i++) begin
      wr(4'(i), 16'hffff);
      rd(4'(i), d);
      chk(d, m[i], "write mask");
    end
    mclear();
    for (int i = 0; i < 5; i++) begin
      rd(4'(i), d);
      chk(d, 16'h0000, "cleared");
    end
  endtask
  task automatic t_sources;
    logic [15:0] ie;
    for (int b = 0; b < 14; b++) begin
      ie = (b < 2) ? 16'h0002 : (b < 4) ? 16'h0001 : (b == 4) ? 16'h0008 :
           (b == 5) ? 16'h0010 : 16'h0004;
      wr(4'h0, 16'h0000);
      pulse(14'(1 << b), 1'b0);
      repeat (4) @(negedge clk);
      chk(16'(irq), 16'h0000, "disabled source");
      wr(4'h0, ie);
      take_irq(b == 2 || b == 3, 3'h7);
      chk(16'(flags), 16'(1 << b), "flag held");
      pulse(14'(1 << b), 1'b1);
      chk(16'(flags), 16'h0000, "flag clear");
    end
  endtask
  task automatic t_levels;
    for (int l = 0; l < 4; l++) begin
      wr(4'h0, {9'h000, 2'(l), 5'h01});
      pulse(14'h0004, 1'b0);
      take_irq(1'b1, 3'(7 - l));
      pulse(14'h0004, 1'b1);
    end
  endtask
  task automatic t_order;
    wr(4'h0, 16'h0003);
    pulse(14'h0005, 1'b0);
    take_irq(1'b0, 3'h7);
    take_irq(1'b1, 3'h7);
    repeat (12) @(negedge clk);
    chk(16'(irq), 16'h0000, "no repeat");
    pulse(14'h0005, 1'b1);
  endtask
  task automatic t_rx_dma;
    mclear();
    MEM.mem[16] = 16'h5555;
    slow = 1'b1;
    for (int i = 0; i < 16; i++) begin
      rxd = 16'ha000 + 16'(i);
      rxv = 1'b1;
      chk(16'(rxr), 16'h0001, "fifo ready");
      @(negedge clk);
    end
    rxd = 16'hbbbb;
    @(negedge clk);
    chk(16'(rxr), 16'h0000, "fifo full");
    rxv = 1'b0;
    wr(4'h8, 16'h0000);
    wr(4'hc, 16'h0010);
    wait_flag(0);
    for (int i = 0; i < 17; i++) begin
      chk(MEM.mem[i], (i < 16) ? 16'ha000 + 16'(i) : 16'h5555, "rx memory");
    end
    chk(16'(rxp), 16'h0001, "rx pair toggled");
    rd(4'h5, d);
    chk(d, 16'h4001, "status word");
    chk(16'(rxr), 16'h0001, "fifo empty");
    mclear();
    chk(16'(rxp), 16'h0000, "rx pair cleared");
  endtask
  task automatic t_tx_dma;
    MEM.mem[32] = 16'h1234;
    MEM.mem[33] = 16'h5678;
    wr(4'ha, 16'h0020);
    wr(4'he, 16'h0002);
    for (int w = 0; w < 2; w++) begin
      for (int i = 0; i < 100 && txv !== 1'b1; i++) @(negedge clk);
      chk(txd, (w == 0) ? 16'h1234 : 16'h5678, "tx word");
      repeat (3) @(negedge clk);
      chk(16'(txv), 16'h0001, "tx held");
      txr = 1'b1;
      @(negedge clk);
      txr = 1'b0;
      chk(16'(txv), 16'h0000, "tx taken");
    end
    wait_flag(2);
    chk(16'(txp), 16'h0001, "tx pair toggled");
    mclear();
    chk(16'(txp), 16'h0000, "tx pair cleared");
    slow = 1'b0;
  endtask
  task automatic t_nxm;
    for (int dir = 0; dir < 2; dir++) begin
      mclear();
      wr(4'h8 + 4'(2 * dir), 16'h8000);
      wr(4'hc + 4'(2 * dir), 16'h0001);
      rxv = (dir == 0);
      @(negedge clk);
      rxv = 1'b0;
      wait_flag(11 - dir);
      chk(16'(flags[10 + dir]), 16'h0000, "other direction");
      rd(4'hc + 4'(2 * dir), d);
      chk(d, 16'h0000, "count zeroed");
    end
    mclear();
  endtask

  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_reset();
    t_clear();
    t_sources();
    t_levels();
    t_order();
    t_rx_dma();
    t_tx_dma();
    t_nxm();
    wrap_up();
  end
endmodule
